/* hdl/read_clear_flag.sv */
`timescale 1ns/1ps

module read_clear_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // events
    input  wire logic set_evt,
    input  wire logic read_set,
    input  wire logic write_zero,
    // state
    output logic      flag
);
    import wdt_pkg::*;

    logic armed_q;

    // a clear only counts once software has seen the flag set
    always_ff @(posedge clk)
    begin
        if (reset)
            armed_q <= 1'b0;
        else if (write_zero && armed_q)
            armed_q <= 1'b0;
        else if (read_set && flag)
            armed_q <= 1'b1;
    end

    // set beats a clear landing in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            flag <= 1'b0;
        else if (set_evt)
            flag <= 1'b1;
        else if (write_zero && armed_q)
            flag <= 1'b0; // (R2)
    end

    a_clear_needs_read: assert property ( // (R2)
        @(posedge clk) disable iff (reset)
        $fell(flag) |-> $past(armed_q && write_zero)
    ) else $error("flag cleared without a prior read of it set");

endmodule

/* hdl/tick_prescaler.sv */
`timescale 1ns/1ps

module tick_prescaler #(
    parameter int TOP_SHIFT = 13
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // control
    input  wire logic       run,
    input  wire logic [2:0] sel,
    // one-cycle count tick
    output logic            tick
);
    import wdt_pkg::*;

    logic [PRESC_W-1:0] div_q;
    logic [2:0]         sel_prev_q;
    logic [7:0]         hit;
    logic               restart;

    // a new select restarts the divider so the first period is whole
    assign restart = !run || (sel != sel_prev_q);

    always_ff @(posedge clk)
    begin
        if (reset)
            sel_prev_q <= SEL_RST;
        else
            sel_prev_q <= sel;
    end

    always_ff @(posedge clk)
    begin
        if (reset || restart)
            div_q <= '0;
        else
            div_q <= div_q + PRESC_W'(1);
    end

    // each code fires when its low divider bits are all ones
    for (genvar i = 0; i < 8; i++)
    begin : g_hit
        localparam int SH = (i == 7) ? TOP_SHIFT : PRESC_SHIFT[i];
        assign hit[i] = &div_q[SH-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            tick <= 1'b0;
        else
            tick <= !restart && hit[sel]; // (R8)
    end

    // helper: cycles since the last tick, for the spacing check
    logic [PRESC_W:0] gap_q;
    logic             primed_q;

    always_ff @(posedge clk)
    begin
        if (reset || restart)
        begin
            gap_q    <= '0;
            primed_q <= 1'b0;
        end
        else if (tick)
        begin
            gap_q    <= '0;
            primed_q <= 1'b1;
        end
        else
            gap_q <= gap_q + (PRESC_W + 1)'(1);
    end

    a_tick_spacing: assert property ( // (R14)
        @(posedge clk) disable iff (reset)
        tick && primed_q && !restart
            |-> 32'(gap_q) == (1 << ((sel == 3'h7) ? TOP_SHIFT : PRESC_SHIFT[sel])) - 1
    ) else $error("tick spacing does not match the selected division");

endmodule

/* hdl/watchdog_interval_timer.sv */
`timescale 1ns/1ps

// How it works
// (R1) interval-mode overflow sets the interval flag
// (R2) flag clears only after read-set then write-zero
// (R3) writing one to the flag does nothing
// (R4) interval-mode overflow raises the interval interrupt
// (R5) watchdog-mode overflow pulses the overflow pin
// (R6) run bit low holds counter at zero
// (R7) run bit high counts; overflow acts per mode
// (R8) select codes 0-3 divide by 2,64,128,256
// (R9) reset enable adds internal reset, same cycle
// (R10) control byte reads; writes need 16-bit format
// (R11) counter read above, written at lower address
// (R12) watchdog overflow sets its own read-clear flag
// (R13) reset type bit picks power-on or manual
// (R14) select codes 4-7 divide by 512,1024,4096,8192
// (R15) counter steps per tick; overflow on wrap
module watchdog_interval_timer #(
    parameter int TOP_SHIFT = 13
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // avalon-mm slave
    input  wire logic [wdt_pkg::ADDR_W-1:0] address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [31:0]                writedata,
    input  wire logic [3:0]                 byteenable,
    output logic      [31:0]                readdata,
    output logic                            waitrequest,
    // interrupt
    output logic                            irq,
    // reset logic and pin
    output logic                            watchdog_overflow_output,
    output logic                            internal_reset_req,
    output logic                            reset_type
);
    import wdt_pkg::*;

    bus_state_t bus_q;
    logic       req;
    logic       accept;
    logic       rd_acc;
    logic       wr_acc;
    logic       wr16;
    logic [7:0] key;
    logic [7:0] wdat;
    logic       wr_ctrl;
    logic       wr_count;
    logic       wr_rst;
    logic       wr_istat;
    logic       wr_imask;
    logic       rd_ctrl;
    logic       rd_rst;
    logic [7:0] rd_mux;

    logic       mode_q;
    logic       run_q;
    logic [2:0] sel_q;
    logic       internal_reset_enable_q;
    logic       reset_type_select_q;
    logic [7:0] count_q;
    logic [1:0] istat_q;
    logic [1:0] mask_q;
    logic [1:0] istat_set;
    logic       tick;
    logic       overflow;
    logic       ovf_interval;
    logic       ovf_watch;
    logic       ival_flag;
    logic       watchdog_overflow_flag_flag;

    // a request is taken on the edge where waitrequest is already low
    assign req    = read || write;
    assign accept = req && (bus_q == BUS_ACK);
    assign rd_acc = read && accept;
    assign wr_acc = write && accept;
    assign key    = writedata[15:8];
    assign wdat   = writedata[7:0];

    // narrower writes to keyed registers fall through silently
    assign wr16     = wr_acc && (byteenable[1:0] == LANES_16); // (R10)
    assign wr_ctrl  = wr16 && (address == IDX_CTRL_STAT) && (key == KEY_CTRL);
    assign wr_count = wr16 && (address == IDX_CTRL_STAT) && (key == KEY_COUNT); // (R11)
    assign wr_rst   = wr16 && (address == IDX_RST_WR) && (key == KEY_RST);
    assign wr_istat = wr_acc && (address == IDX_IRQ_STATUS) && byteenable[0];
    assign wr_imask = wr_acc && (address == IDX_IRQ_MASK) && byteenable[0];
    assign rd_ctrl  = rd_acc && (address == IDX_CTRL_STAT);
    assign rd_rst   = rd_acc && (address == IDX_RST_RD);

    // one wait cycle on every access keeps read data a flop output
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bus_q       <= BUS_IDLE;
            waitrequest <= 1'b1;
        end
        else
        begin
            case (bus_q)
                BUS_IDLE:
                begin
                    if (req)
                    begin
                        bus_q       <= BUS_ACK;
                        waitrequest <= 1'b0;
                    end
                end
                BUS_ACK:
                begin
                    bus_q       <= BUS_IDLE;
                    waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_q       <= BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // read mux; byte reads of any register, unmapped reads give zero
    always_comb
    begin
        rd_mux = 8'h00;
        case (address)
            IDX_CTRL_STAT:  rd_mux = {ival_flag, mode_q, run_q, CS_FIXED_ONES, sel_q}; // (R10)
            IDX_COUNT_RD:   rd_mux = count_q; // (R11)
            IDX_RST_RD:     rd_mux = {watchdog_overflow_flag_flag, internal_reset_enable_q, reset_type_select_q, RS_FIXED_ONES};
            IDX_IRQ_STATUS: rd_mux = {6'h00, istat_q};
            IDX_IRQ_MASK:   rd_mux = {6'h00, mask_q};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            readdata <= 32'h0000_0000;
        else if (bus_q == BUS_IDLE && read)
            readdata <= {24'h00_0000, rd_mux};
    end

    // control fields; the flag bit of the write only matters as a clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode_q <= 1'b0;
            run_q  <= 1'b0;
            sel_q  <= SEL_RST;
        end
        else if (wr_ctrl)
        begin
            mode_q <= wdat[MODE_BIT];
            run_q  <= wdat[RUN_BIT];
            sel_q  <= wdat[2:0]; // (R8)
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            internal_reset_enable_q <= 1'b0;
            reset_type_select_q <= 1'b0;
        end
        else if (wr_rst)
        begin
            internal_reset_enable_q <= wdat[INTERNAL_RESET_ENABLE_BIT];
            reset_type_select_q <= wdat[RESET_TYPE_SELECT_BIT]; // (R13)
        end
    end

    tick_prescaler #(
        .TOP_SHIFT (TOP_SHIFT)
    ) u_presc (
        .clk   (clk),
        .reset (reset),
        .run   (run_q),
        .sel   (sel_q),
        .tick  (tick)
    );

    // counter: a software write wins over a tick in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset || !run_q)
            count_q <= COUNT_RST; // (R6)
        else if (wr_count)
            count_q <= wdat; // (R11)
        else if (tick)
            count_q <= count_q + 8'h01; // (R15)
    end

    assign overflow     = run_q && tick && !wr_count && (count_q == COUNT_MAX); // (R15)
    assign ovf_interval = overflow && !mode_q; // (R7)
    assign ovf_watch    = overflow && mode_q;

    // the flags read back the value seen at the decode edge
    read_clear_flag u_ival_flag (
        .clk        (clk),
        .reset      (reset),
        .set_evt    (ovf_interval), // (R1)
        .read_set   (rd_ctrl && readdata[FLAG_BIT]),
        .write_zero (wr_ctrl && !wdat[FLAG_BIT]), // (R3)
        .flag       (ival_flag)
    );

    read_clear_flag u_watchdog_overflow_flag_flag (
        .clk        (clk),
        .reset      (reset),
        .set_evt    (ovf_watch), // (R12)
        .read_set   (rd_rst && readdata[FLAG_BIT]),
        .write_zero (wr_rst && !wdat[FLAG_BIT]),
        .flag       (watchdog_overflow_flag_flag)
    );

    // pin and internal reset leave together, one cycle each
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            watchdog_overflow_output <= 1'b0;
            internal_reset_req       <= 1'b0;
            reset_type               <= 1'b0;
        end
        else
        begin
            watchdog_overflow_output <= ovf_watch; // (R5)
            internal_reset_req       <= ovf_watch && internal_reset_enable_q; // (R9)
            reset_type               <= reset_type_select_q; // (R13)
        end
    end

    // sticky interrupt status, write one to clear; the set wins
    assign istat_set[IRQ_INTERVAL] = ovf_interval; // (R4)
    assign istat_set[IRQ_WATCHDOG] = ovf_watch;

    always_ff @(posedge clk)
    begin
        if (reset)
            istat_q <= 2'h0;
        else if (wr_istat)
            istat_q <= (istat_q & ~writedata[1:0]) | istat_set;
        else
            istat_q <= istat_q | istat_set;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            mask_q <= MASK_RST;
        else if (wr_imask)
            mask_q <= writedata[1:0];
    end

    // mask resets open so interval overflow interrupts out of reset
    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(istat_q & mask_q); // (R4)
    end

    a_interval_flag_set: assert property ( // (R1)
        @(posedge clk) disable iff (reset)
        ovf_interval |=> ival_flag
    ) else $error("interval overflow did not set the flag");

    a_flag_write_one: assert property ( // (R3)
        @(posedge clk) disable iff (reset)
        wr_ctrl && wdat[FLAG_BIT] && !ival_flag && !ovf_interval |=> !ival_flag
    ) else $error("writing one set the interval flag");

    a_interval_irq_path: assert property ( // (R4)
        @(posedge clk) disable iff (reset)
        ovf_interval && mask_q[IRQ_INTERVAL] && !wr_imask |=> ##1 irq
    ) else $error("interval overflow did not raise the interrupt");

    a_pin_from_mode: assert property ( // (R5)
        @(posedge clk) disable iff (reset)
        watchdog_overflow_output |-> $past(mode_q && overflow)
    ) else $error("overflow pin pulsed outside watchdog mode");

    a_counter_held: assert property ( // (R6)
        @(posedge clk) disable iff (reset)
        !run_q |=> count_q == COUNT_RST
    ) else $error("counter moved while stopped");

    a_counter_steps: assert property ( // (R15)
        @(posedge clk) disable iff (reset)
        run_q && tick && !wr_count ##1 run_q |-> count_q == $past(count_q) + 8'h01
    ) else $error("counter did not step on a tick");

    a_fast_tick_rate: assert property ( // (R8)
        @(posedge clk) disable iff (reset)
        (run_q && sel_q == 3'h0 && $past(sel_q) == 3'h0 && tick)
            ##1 (run_q && sel_q == 3'h0 && !wr_ctrl) |=> tick
    ) else $error("divide-by-two tick missing");

    a_reset_with_pin: assert property ( // (R9)
        @(posedge clk) disable iff (reset)
        ovf_watch && internal_reset_enable_q |=> internal_reset_req && watchdog_overflow_output
    ) else $error("internal reset not with the overflow pin");

    a_narrow_write_ignored: assert property ( // (R10)
        @(posedge clk) disable iff (reset)
        wr_acc && address == IDX_CTRL_STAT && byteenable[1:0] != LANES_16
            |=> $stable(mode_q) && $stable(sel_q)
    ) else $error("narrow write changed the control register");

    a_count_written: assert property ( // (R11)
        @(posedge clk) disable iff (reset)
        wr_count && run_q |=> count_q == $past(wdat)
    ) else $error("counter write not applied");

    a_watchdog_flag_set: assert property ( // (R12)
        @(posedge clk) disable iff (reset)
        ovf_watch |=> watchdog_overflow_flag_flag
    ) else $error("watchdog overflow did not set its flag");

    a_reset_type_held: assert property ( // (R13)
        @(posedge clk) disable iff (reset)
        wr_rst |=> ##1 reset_type == $past(wdat[RESET_TYPE_SELECT_BIT], 2)
    ) else $error("reset type does not follow its select bit");

endmodule

/* hdl/wdt_pkg.sv */
package wdt_pkg;

    // register word indices; byte address is four times the index
    localparam int              ADDR_W         = 27;
    localparam logic [26:0]     IDX_IRQ_STATUS = 27'h5ff_ffb0;
    localparam logic [26:0]     IDX_IRQ_MASK   = 27'h5ff_ffb1;
    localparam logic [26:0]     IDX_CTRL_STAT  = 27'h5ff_ffb8;
    localparam logic [26:0]     IDX_COUNT_RD   = 27'h5ff_ffb9;
    localparam logic [26:0]     IDX_RST_WR     = 27'h5ff_ffba;
    localparam logic [26:0]     IDX_RST_RD     = 27'h5ff_ffbb;

    // upper byte of a 16-bit write picks the target
    localparam logic [7:0]      KEY_CTRL       = 8'hc3;
    localparam logic [7:0]      KEY_COUNT      = 8'h3c;
    localparam logic [7:0]      KEY_RST        = 8'h96;
    localparam logic [1:0]      LANES_16       = 2'h3;

    // field positions of the control/status bytes
    localparam int              FLAG_BIT       = 7;
    localparam int              MODE_BIT       = 6;
    localparam int              RUN_BIT        = 5;
    localparam int              INTERNAL_RESET_ENABLE_BIT       = 6;
    localparam int              RESET_TYPE_SELECT_BIT       = 5;
    localparam logic [1:0]      CS_FIXED_ONES  = 2'h3;
    localparam logic [4:0]      RS_FIXED_ONES  = 5'h1f;

    // reset values and counter maximum
    localparam logic [2:0]      SEL_RST        = 3'h0;
    localparam logic [7:0]      COUNT_RST      = 8'h00;
    localparam logic [7:0]      COUNT_MAX      = 8'hff;
    localparam logic [1:0]      MASK_RST       = 2'h3;

    // interrupt status bits
    localparam int              IRQ_INTERVAL   = 0;
    localparam int              IRQ_WATCHDOG   = 1;

    // prescaler: divide by two to the power of the shift, per select code
    localparam int              PRESC_W        = 13;
    localparam int              PRESC_SHIFT [8] = '{1, 6, 7, 8, 9, 10, 12, 13};

    // bus handshake states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

endpackage

/* test/irq_reset_sink.sv */
`timescale 1ns/1ps

module irq_reset_sink (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // lines from the timer
    input  wire logic overflow_pin,
    input  wire logic reset_req,
    // tallies for the bench
    output int        pin_pulses,
    output int        joint_pulses,
    output int        lone_resets
);
    // counts high cycles, so a pulse wider than one cycle shows as extra counts
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_pulses   <= 0;
            joint_pulses <= 0;
            lone_resets  <= 0;
        end
        else
        begin
            if (overflow_pin === 1'b1)
                pin_pulses <= pin_pulses + 1;
            if (overflow_pin === 1'b1 && reset_req === 1'b1)
                joint_pulses <= joint_pulses + 1;
            if (overflow_pin !== 1'b1 && reset_req === 1'b1)
                lone_resets <= lone_resets + 1;
        end
    end
endmodule

/* test/watchdog_interval_timer_bench.sv */
`timescale 1ns/1ps

module watchdog_interval_timer_bench;
    import wdt_pkg::*;
    localparam int TOP = 3;
    // divide ratios per select code; code 7 shortened through the parameter
    localparam int DIV [8] = '{2, 64, 128, 256, 512, 1024, 4096, 1 << TOP};

    logic              clk;
    logic              reset;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              irq;
    logic              ovf_pin;
    logic              rst_req;
    logic              reset_type;
    int                pin_pulses;
    int                joint_pulses;
    int                lone_resets;
    int                miscompares;
    int                n_tests;
    logic [7:0]        v;

    watchdog_interval_timer #(.TOP_SHIFT(TOP)) DUT (
        .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .watchdog_overflow_output(ovf_pin),
        .internal_reset_req(rst_req), .reset_type(reset_type)
    );

    irq_reset_sink sink (
        .clk(clk), .reset(reset), .overflow_pin(ovf_pin), .reset_req(rst_req),
        .pin_pulses(pin_pulses), .joint_pulses(joint_pulses), .lone_resets(lone_resets)
    );

    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // holds the request until waitrequest is sampled low; a stuck slave ends the run
    task automatic wait_take;
        int n;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        if (n == 20)
        begin
            miscompares++;
            wrap_up();
        end
    endtask

    task automatic bus_write(input logic [26:0] idx, input logic [15:0] d,
                             input logic [3:0] be = 4'h3);
        @(posedge clk);
        address    <= idx;
        writedata  <= {16'h0000, d};
        byteenable <= be;
        write      <= 1'b1;
        wait_take();
        write      <= 1'b0;
    endtask

    task automatic bus_read(input logic [26:0] idx, output logic [7:0] d);
        @(posedge clk);
        address <= idx;
        read    <= 1'b1;
        wait_take();
        d = readdata[7:0];
        check("upper_bits", readdata[31:24] | readdata[23:16] | readdata[15:8], 8'h00);
        read    <= 1'b0;
    endtask

    task automatic expect_reg(input string name, input logic [26:0] idx, input logic [7:0] e);
        logic [7:0] d;
        bus_read(idx, d);
        check(name, d, e);
    endtask

    // bounded wait on the interrupt or on the overflow pin tally
    task automatic wait_event(input bit want_pin, input int bound);
        int n;
        for (n = 0; n < bound; n++)
        begin
            @(posedge clk);
            if (!want_pin && irq === 1'b1)
                break;
            if (want_pin && pin_pulses > 0)
                break;
        end
        if (n == bound)
        begin
            miscompares++;
            wrap_up();
        end
    endtask

    initial
    begin
        reset = 1'b1;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        // reset values and an unmapped place
        expect_reg("ctrl_reset", IDX_CTRL_STAT, 8'h18);
        expect_reg("count_reset", IDX_COUNT_RD, 8'h00);
        expect_reg("rst_reset", IDX_RST_RD, 8'h1f);
        expect_reg("mask_reset", IDX_IRQ_MASK, 8'h03);
        expect_reg("unmapped", 27'h000_0010, 8'h00);
        check("reset_type_reset", reset_type, 8'h00);
        // counter held while stopped
        bus_write(IDX_CTRL_STAT, {KEY_COUNT, 8'h55});
        expect_reg("count_held", IDX_COUNT_RD, 8'h00);
        // every select code: about four ticks in four divide periods
        for (int c = 0; c < 8; c++)
        begin
            bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h20 | 8'(c)});
            repeat (4 * DIV[c]) @(posedge clk);
            bus_read(IDX_COUNT_RD, v);
            check("tick_rate", 8'(v >= 3 && v <= 6), 8'h01);
            bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h00});
            expect_reg("count_cleared", IDX_COUNT_RD, 8'h00);
        end
        // interval overflow from a preloaded counter
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h20});
        bus_write(IDX_CTRL_STAT, {KEY_COUNT, 8'hfe});
        wait_event(1'b0, 50);
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h00});
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h80});
        expect_reg("flag_kept", IDX_CTRL_STAT, 8'h98);
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h80});
        expect_reg("flag_one_ignored", IDX_CTRL_STAT, 8'h98);
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h00});
        expect_reg("flag_cleared", IDX_CTRL_STAT, 8'h18);
        check("no_pin_interval", 8'(pin_pulses), 8'h00);
        // interrupt status, mask and clear
        expect_reg("status_interval", IDX_IRQ_STATUS, 8'h01);
        bus_write(IDX_IRQ_MASK, 16'h0000, 4'h1);
        repeat (2) @(posedge clk);
        check("irq_masked", irq, 8'h00);
        bus_write(IDX_IRQ_MASK, 16'h0003, 4'h1);
        repeat (2) @(posedge clk);
        check("irq_unmasked", irq, 8'h01);
        bus_write(IDX_IRQ_STATUS, 16'h0001, 4'h1);
        repeat (2) @(posedge clk);
        check("irq_cleared", irq, 8'h00);
        expect_reg("status_cleared", IDX_IRQ_STATUS, 8'h00);
        // refused writes: wrong key and too narrow a write
        bus_write(IDX_CTRL_STAT, {8'h00, 8'h47});
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h47}, 4'h1);
        expect_reg("ctrl_refused", IDX_CTRL_STAT, 8'h18);
        // watchdog overflow with internal reset, manual type
        bus_write(IDX_RST_WR, {KEY_RST, 8'h60});
        expect_reg("rst_set", IDX_RST_RD, 8'h7f);
        check("reset_type_manual", reset_type, 8'h01);
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h67});
        bus_write(IDX_CTRL_STAT, {KEY_COUNT, 8'hfe});
        wait_event(1'b1, 100);
        bus_write(IDX_CTRL_STAT, {KEY_CTRL, 8'h47});
        check("pin_width", 8'(pin_pulses), 8'h01);
        check("joint_reset", 8'(joint_pulses), 8'h01);
        check("lone_reset", 8'(lone_resets), 8'h00);
        expect_reg("no_interval_flag", IDX_CTRL_STAT, 8'h5f);
        expect_reg("wflag_set", IDX_RST_RD, 8'hff);
        expect_reg("status_watchdog", IDX_IRQ_STATUS, 8'h02);
        bus_write(IDX_RST_WR, {KEY_RST, 8'h60});
        expect_reg("wflag_cleared", IDX_RST_RD, 8'h7f);
        wrap_up();
    end

    // overall guard against a hang anywhere
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule
